// >>> design/power_down_pkg.sv
// Package for the power-down clock configuration block: register map,
// field positions, reset values, divider and wait constants, bus carriers.
// Assumes a 32-bit APB slave port with byte addresses and one word per register.
package power_down_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam int                ADDR_W           = 4;
   localparam logic [ADDR_W-1:0] OFS_CONTROL_ONE  = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_CONTROL_TWO  = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_STATUS       = 4'h8;

   // Control one fields.
   localparam int               C1_STANDBY       = 7;
   localparam int               C1_WAIT_HI       = 6;
   localparam int               C1_WAIT_LO       = 4;
   localparam int               C1_LOW_SPEED     = 3;
   localparam int               C1_MED_HI        = 1;
   localparam int               C1_MED_LO        = 0;
   localparam logic [7:0]       C1_RESET         = 8'h07;
   localparam logic [7:0]       C1_FIXED_ONES    = 8'h04;

   // Control two fields.
   localparam int               C2_NOISE         = 4;
   localparam int               C2_DIRECT        = 3;
   localparam int               C2_MEDIUM        = 2;
   localparam int               C2_SUB_HI        = 1;
   localparam int               C2_SUB_LO        = 0;
   localparam logic [7:0]       C2_RESET         = 8'hF0;
   localparam logic [7:0]       C2_FIXED_ONES    = 8'hE0;

   // ----------------------------------------------------------------------
   // Dividers and waits
   // ----------------------------------------------------------------------
   localparam int               PRESC_W          = 7;
   localparam int               MED_BASE_BIT     = 3;
   localparam logic [3:0]       NOISE_SLOW_MASK  = 4'hF;
   localparam logic [3:0]       NOISE_FAST_MASK  = 4'h3;
   localparam int               SUB_W            = 3;
   localparam int               WAIT_W           = 18;
   localparam logic [WAIT_W-1:0] WAIT_1024       = 18'h00400;
   localparam logic [WAIT_W-1:0] WAIT_2048       = 18'h00800;
   localparam logic [WAIT_W-1:0] WAIT_4096       = 18'h01000;
   localparam logic [WAIT_W-1:0] WAIT_EXT_CLOCK  = 18'h00002;
   localparam logic [WAIT_W-1:0] WAIT_8         = 18'h00008;
   localparam logic [WAIT_W-1:0] WAIT_16        = 18'h00010;

   // ----------------------------------------------------------------------
   // Operating modes, one-hot
   // ----------------------------------------------------------------------
   typedef enum logic [8:0] {
      ACT_HIGH  = 9'h001,
      ACT_MED   = 9'h002,
      SLP_HIGH  = 9'h004,
      SLP_MED   = 9'h008,
      SUB_ACT   = 9'h010,
      SUB_SLP   = 9'h020,
      STANDBY   = 9'h040,
      WATCH     = 9'h080,
      STAB_WAIT = 9'h100
   } mode_type;

   // ----------------------------------------------------------------------
   // Bus carriers
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0]       pwdata;
   } apb_req_type;

   typedef struct packed {
      logic [31:0]       prdata;
      logic              pready;
      logic              pslverr;
   } apb_rsp_type;

endpackage

// >>> design/power_down_clock_config.sv
// Power-down clock configuration: two control registers on APB, the
// medium-speed and subactive clock dividers, watch clock noise filter,
// the sleep and wake mode sequencer and the oscillation-stabilisation wait.
// Assumes mclk is the oscillator clock, sleep_exec and wake_irq are one-cycle
// pulses from logic on mclk, and watch_clk arrives from a pin.
// How it works
// - medium clock is oscillator divided by 16, 32, 64 or 128 per select.
// - both medium select bits reset to one and are read/write.
// - basic variant wait codes give 8192,16384,1024,2048,4096,2,8,16 states.
// - extended variant swaps codes 2,3,4 for 32768, 65536 and 131072 states.
// - upper three bits of control two read as one and ignore writes.
// - watch clock sampled at oscillator/16 when select is 0, /4 when 1.
// - direct flag with standby, low-speed, medium and timer bits picks mode.
// - wake resumes active high-speed if medium flag 0, medium-speed if 1.
// - subactive clock is watch clock divided by 8, 4 or 2; resets to 00.
// - new subactive division applies only after the next sleep instruction.
// - sleep goes to sleep/subsleep with standby select 0, standby/watch with 1.
// - stabilisation wait holds processor idle when leaving standby or watch for active by interrupt.
`timescale 1ns/10ps

module power_down_clock_config #(
   parameter bit          EXT_VARIANT = 1'b0,
   parameter int unsigned WAIT_8192   = 8192,
   parameter int unsigned WAIT_16384  = 16384,
   parameter int unsigned WAIT_32768  = 32768,
   parameter int unsigned WAIT_65536  = 65536,
   parameter int unsigned WAIT_131072 = 131072
) (
   input  wire logic                      mclk,
   input  wire logic                      rst_n,
   input  wire power_down_pkg::apb_req_type apb_req,
   output      power_down_pkg::apb_rsp_type apb_rsp,
   input  wire logic                      sleep_exec,
   input  wire logic                      wake_irq,
   input  wire logic                      timer_clock_source_bit,
   input  wire logic                      watch_clk,
   output      power_down_pkg::mode_type  mode,
   output      logic                      cpu_hold,
   output      logic                      medium_clk,
   output      logic                      sub_clk,
   output      logic                      watch_clk_clean
);
   import power_down_pkg::*;

   // ----------------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------------
   if (WAIT_131072 >= (1 << WAIT_W) || WAIT_8192 < 1) begin : g_bad_wait
      $error("Wait count parameters do not fit the wait counter.");
   end

   // ----------------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------------
   logic [7:0]          ctrl_one_reg;
   logic [7:0]          ctrl_two_reg;
   logic [PRESC_W-1:0]  presc_reg;
   logic [1:0]          med_sel_reg;
   logic                med_clk_reg;
   logic                ws1_reg;
   logic                ws2_reg;
   logic                ws3_reg;
   logic                sample_reg;
   logic                filt_reg;
   logic [SUB_W-1:0]    sub_cnt_reg;
   logic [1:0]          sub_pend_reg;
   logic [1:0]          sub_sel_reg;
   logic                sub_clk_reg;
   logic [WAIT_W-1:0]   wait_cnt_reg;
   mode_type            mode_reg;
   mode_type            mode_next;
   logic [31:0]         prdata_reg;

   // ----------------------------------------------------------------------
   // APB decode; the slave answers in the first access cycle.
   // ----------------------------------------------------------------------
   wire logic hit_one   = apb_req.paddr == OFS_CONTROL_ONE;
   wire logic hit_two   = apb_req.paddr == OFS_CONTROL_TWO;
   wire logic hit_stat  = apb_req.paddr == OFS_STATUS;
   wire logic mapped    = hit_one | hit_two | hit_stat;
   wire logic access    = apb_req.psel & apb_req.penable;
   wire logic wr_one    = access & apb_req.pwrite & hit_one;
   wire logic wr_two    = access & apb_req.pwrite & hit_two;
   wire logic rd_setup  = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;

   // Status shows the live mode, the applied sub select and the wait countdown.
   wire logic [31:0] status_word = {3'h0, wait_cnt_reg, sub_sel_reg, 9'(mode_reg)};
   wire logic [31:0] read_word   = hit_one  ? {24'h000000, ctrl_one_reg} :
                                   hit_two  ? {24'h000000, ctrl_two_reg} :
                                   hit_stat ? status_word : 32'h00000000;

   assign apb_rsp = '{prdata: prdata_reg, pready: 1'b1, pslverr: access & ~mapped};

   // Read data is captured in the setup cycle so it comes from a flip-flop.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_reg <= 32'h00000000;
      end else if (rd_setup) begin
         prdata_reg <= read_word;
      end
   end

   // Control registers; fixed bits are forced so writes cannot touch them.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_one_reg <= C1_RESET;
         ctrl_two_reg <= C2_RESET;
      end else begin
         if (wr_one) begin
            ctrl_one_reg <= apb_req.pwdata[7:0] | C1_FIXED_ONES;
         end
         if (wr_two) begin
            ctrl_two_reg <= apb_req.pwdata[7:0] | C2_FIXED_ONES;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Field views
   // ----------------------------------------------------------------------
   wire logic       standby_select        = ctrl_one_reg[C1_STANDBY];
   wire logic [2:0] stab_wait_sel         = ctrl_one_reg[C1_WAIT_HI:C1_WAIT_LO];
   wire logic       low_speed_on          = ctrl_one_reg[C1_LOW_SPEED];
   wire logic [1:0] medium_clk_sel        = ctrl_one_reg[C1_MED_HI:C1_MED_LO];
   wire logic       noise_sample_rate_sel = ctrl_two_reg[C2_NOISE];
   wire logic       direct_transfer_flag  = ctrl_two_reg[C2_DIRECT];
   wire logic       medium_speed_flag     = ctrl_two_reg[C2_MEDIUM];
   wire logic [1:0] sub_clk_sel           = ctrl_two_reg[C2_SUB_HI:C2_SUB_LO];

   // ----------------------------------------------------------------------
   // Medium-speed divider
   // ----------------------------------------------------------------------
   // Every divided clock is low right after the prescaler wraps, so taking a
   // new ratio only there gives a full-width first phase at any of the four rates.
   wire logic presc_wrap = &presc_reg;
   wire logic [2:0] med_bit = 3'(MED_BASE_BIT) + {1'b0, med_sel_reg};

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         presc_reg   <= '0;
         med_sel_reg <= 2'h3;
         med_clk_reg <= 1'b0;
      end else begin
         presc_reg   <= presc_reg + 1'b1;
         med_clk_reg <= presc_reg[med_bit];
         if (presc_wrap) begin
            med_sel_reg <= medium_clk_sel;
         end
      end
   end

   assign medium_clk = med_clk_reg;

   // ----------------------------------------------------------------------
   // Watch clock synchroniser and noise filter
   // ----------------------------------------------------------------------
   // A level is taken only when two samples at the chosen rate agree, which
   // rejects a glitch shorter than one sampling interval.
   wire logic noise_tick = noise_sample_rate_sel ?
                           ((presc_reg[3:0] & NOISE_FAST_MASK) == NOISE_FAST_MASK) :
                           ((presc_reg[3:0] & NOISE_SLOW_MASK) == NOISE_SLOW_MASK);
   wire logic filt_next  = (noise_tick && ws2_reg == ws3_reg && ws3_reg == sample_reg) ?
                           ws3_reg : filt_reg;
   wire logic watch_rise = filt_next & ~filt_reg;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ws1_reg    <= 1'b0;
         ws2_reg    <= 1'b0;
         ws3_reg    <= 1'b0;
         sample_reg <= 1'b0;
         filt_reg   <= 1'b0;
      end else begin
         ws1_reg  <= watch_clk;
         ws2_reg  <= ws1_reg;
         ws3_reg  <= ws2_reg;
         filt_reg <= filt_next;
         if (noise_tick) begin
            sample_reg <= ws3_reg;
         end
      end
   end

   assign watch_clk_clean = filt_reg;

   // ----------------------------------------------------------------------
   // Subactive divider
   // ----------------------------------------------------------------------
   // The select is copied at the sleep instruction and then applied at the
   // counter wrap, so a write alone never disturbs the running clock.
   wire logic [1:0] sub_bit = sub_sel_reg[1] ? 2'h0 : (sub_sel_reg[0] ? 2'h1 : 2'h2);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sub_cnt_reg  <= '0;
         sub_pend_reg <= 2'h0;
         sub_sel_reg  <= 2'h0;
         sub_clk_reg  <= 1'b0;
      end else begin
         if (sleep_exec) begin
            sub_pend_reg <= sub_clk_sel;
         end
         if (watch_rise) begin
            sub_cnt_reg <= sub_cnt_reg + 1'b1;
            if (&sub_cnt_reg) begin
               sub_sel_reg <= sub_pend_reg;
            end
         end
         sub_clk_reg <= sub_cnt_reg[sub_bit];
      end
   end

   assign sub_clk = sub_clk_reg;

   // ----------------------------------------------------------------------
   // Stabilisation wait length
   // ----------------------------------------------------------------------
   function automatic logic [WAIT_W-1:0] wait_len(input logic [2:0] code);
      logic [WAIT_W-1:0] len;
      len = WAIT_W'(WAIT_8192);
      unique case (code)
         3'h0: len = WAIT_W'(WAIT_8192);
         3'h1: len = WAIT_W'(WAIT_16384);
         3'h2: len = EXT_VARIANT ? WAIT_W'(WAIT_32768) : WAIT_1024;
         3'h3: len = EXT_VARIANT ? WAIT_W'(WAIT_65536) : WAIT_2048;
         3'h4: len = EXT_VARIANT ? WAIT_W'(WAIT_131072) : WAIT_4096;
         3'h5: len = WAIT_EXT_CLOCK;
         3'h6: len = WAIT_8;
         3'h7: len = WAIT_16;
      endcase
      return len;
   endfunction

   // ----------------------------------------------------------------------
   // Mode sequencer
   // ----------------------------------------------------------------------
   wire mode_type resume_mode = medium_speed_flag ? ACT_MED : ACT_HIGH;
   wire logic     wait_done   = wait_cnt_reg == '0;

   // Sleep from an active mode; a combination with no documented target stays.
   always_comb begin
      mode_next = mode_reg;
      unique case (mode_reg)
         ACT_HIGH, ACT_MED: begin
            if (sleep_exec) begin
               if (direct_transfer_flag) begin
                  if (!low_speed_on) begin
                     mode_next = resume_mode;
                  end else if (standby_select && timer_clock_source_bit) begin
                     mode_next = SUB_ACT;
                  end
               end else if (!standby_select) begin
                  if (!low_speed_on) begin
                     mode_next = medium_speed_flag ? SLP_MED : SLP_HIGH;
                  end else if (timer_clock_source_bit) begin
                     mode_next = SUB_SLP;
                  end
               end else if (timer_clock_source_bit) begin
                  mode_next = WATCH;
               end else if (!low_speed_on) begin
                  mode_next = STANDBY;
               end
            end
         end
         SUB_ACT: begin
            if (sleep_exec) begin
               if (direct_transfer_flag && !low_speed_on) begin
                  mode_next = STAB_WAIT;
               end else if (!direct_transfer_flag && !standby_select &&
                            low_speed_on && timer_clock_source_bit) begin
                  mode_next = SUB_SLP;
               end else if (!direct_transfer_flag && standby_select &&
                            timer_clock_source_bit) begin
                  mode_next = WATCH;
               end
            end
         end
         SLP_HIGH, SLP_MED: begin
            if (wake_irq) begin
               mode_next = resume_mode;
            end
         end
         SUB_SLP: begin
            if (wake_irq) begin
               mode_next = SUB_ACT;
            end
         end
         STANDBY: begin
            if (wake_irq) begin
               mode_next = STAB_WAIT;
            end
         end
         WATCH: begin
            if (wake_irq) begin
               mode_next = low_speed_on ? SUB_ACT : STAB_WAIT;
            end
         end
         STAB_WAIT: begin
            if (wait_done) begin
               mode_next = resume_mode;
            end
         end
         default: mode_next = ACT_HIGH;
      endcase
   end

   // The counter is loaded on entry so the wait lasts exactly its count.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg     <= ACT_HIGH;
         wait_cnt_reg <= '0;
      end else begin
         mode_reg <= mode_next;
         if (mode_next == STAB_WAIT && mode_reg != STAB_WAIT) begin
            wait_cnt_reg <= wait_len(stab_wait_sel) - 1'b1;
         end else if (mode_reg == STAB_WAIT && !wait_done) begin
            wait_cnt_reg <= wait_cnt_reg - 1'b1;
         end
      end
   end

   assign mode     = mode_reg;
   assign cpu_hold = ~(mode_reg == ACT_HIGH || mode_reg == ACT_MED ||
                       mode_reg == SUB_ACT);

endmodule

// >>> verification/power_down_monitor.sv
// Port-level assertions for the power-down clock configuration block.
// Assumes one clock domain and the port names of power_down_clock_config.
`timescale 1ns/10ps

module power_down_monitor
   import power_down_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire apb_req_type apb_req,
   input wire apb_rsp_type apb_rsp,
   input wire logic        sleep_exec,
   input wire logic        wake_irq,
   input wire logic        timer_clock_source_bit,
   input wire mode_type    mode,
   input wire logic        cpu_hold,
   input wire logic        medium_clk
);
   // ---------------------------------------------------------------
   // Shadow copies of the control registers and a level-length counter
   // ---------------------------------------------------------------
   logic [7:0] c1_reg;
   logic [7:0] c2_reg;
   logic [7:0] run_reg;
   wire        wr_take = apb_req.psel & apb_req.penable & apb_req.pwrite;
   wire        rd_take = apb_req.psel & apb_req.penable & ~apb_req.pwrite;

   // The shadows follow completed writes so sleep decisions can be predicted.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         c1_reg  <= C1_RESET;
         c2_reg  <= C2_RESET;
         run_reg <= 8'h00;
      end else begin
         run_reg <= $changed(medium_clk) ? 8'h00 : run_reg + 8'h01;
         if (wr_take && apb_req.paddr == OFS_CONTROL_ONE)
            c1_reg <= apb_req.pwdata[7:0] | C1_FIXED_ONES;
         if (wr_take && apb_req.paddr == OFS_CONTROL_TWO)
            c2_reg <= apb_req.pwdata[7:0] | C2_FIXED_ONES;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   // Fixed bits, select bits, sleep targets, waits and resume modes.
   a_fixed_ones_read: assert property (rd_take && apb_req.paddr == OFS_CONTROL_TWO
      |-> apb_rsp.prdata[7:5] == 3'h7) else $error("fixed bits not one");
   a_med_sel_read: assert property (rd_take && apb_req.paddr == OFS_CONTROL_ONE
      |-> apb_rsp.prdata[1:0] == c1_reg[1:0]) else $error("medium select readback");
   a_sleep_deep: assert property (mode == ACT_HIGH && sleep_exec && c1_reg[7]
      && !c1_reg[3] && !c2_reg[3] && !timer_clock_source_bit |=> mode == STANDBY)
      else $error("no standby entry");
   a_sleep_light: assert property (mode == ACT_HIGH && sleep_exec && !c1_reg[7]
      && !c1_reg[3] && !c2_reg[3] |=> mode == ($past(c2_reg[2]) ? SLP_MED : SLP_HIGH))
      else $error("wrong sleep mode");
   a_wait_hold: assert property (mode == STAB_WAIT |-> cpu_hold)
      else $error("cpu runs in wait");
   a_run_free: assert property (mode inside {ACT_HIGH, ACT_MED, SUB_ACT} |-> !cpu_hold)
      else $error("cpu held while running");
   a_wake_wait: assert property (mode == STANDBY && wake_irq |=> mode == STAB_WAIT)
      else $error("no wait after wake");
   a_wait_min: assert property ($rose(mode == STAB_WAIT)
      |-> mode == STAB_WAIT ##1 mode == STAB_WAIT) else $error("wait too short");
   a_wake_resume: assert property ($past(mode) == STAB_WAIT && mode != STAB_WAIT
      |-> mode == ($past(c2_reg[2]) ? ACT_MED : ACT_HIGH)) else $error("wrong resume mode");
   a_no_runt: assert property ($changed(medium_clk) |-> run_reg >= 8'h07)
      else $error("medium clock runt");

   c_wait_done: cover property (mode == STAB_WAIT ##1 mode != STAB_WAIT);
   c_standby: cover property (mode == STANDBY);
   c_sleep_med: cover property (mode == SLP_MED);
endmodule

bind power_down_clock_config power_down_monitor power_down_monitor_inst (
   .mclk(mclk), .rst_n(rst_n),
   .apb_req(apb_req), .apb_rsp(apb_rsp), .sleep_exec(sleep_exec), .wake_irq(wake_irq),
   .timer_clock_source_bit(timer_clock_source_bit), .mode(mode), .cpu_hold(cpu_hold),
   .medium_clk(medium_clk));

// >>> verification/tb_power_down_clock_config.sv
// Self-checking bench for the power-down clock block: registers over APB,
// divider periods, sleep and wake sequencing and stabilisation waits.
// Assumes the package is compiled first; long waits are shortened by parameter.
`timescale 1ns/10ps

module tb_power_down_clock_config;
   import power_down_pkg::*;
   localparam int W0 = 20;
   localparam int W1 = 30;
   typedef struct {logic [3:0] a; logic [7:0] w; logic [31:0] r; logic e;} row_type;
   logic        mclk;
   logic        rst_n;
   apb_req_type apb_req;
   apb_rsp_type apb_rsp;
   logic        sleep_exec;
   logic        wake_irq;
   logic        watch_clk;
   mode_type    mode;
   logic        cpu_hold;
   logic        medium_clk;
   logic        sub_clk;
   logic        watch_clk_clean;
   logic [4:0]  wcnt_reg;
   logic [31:0] rd;
   logic        er;
   int          err_count;
   int          n_compared;
   int          p;
   int          n;
   int          exp_wait[8] = '{W0, W1, 1024, 2048, 4096, 2, 8, 16};
   logic        timer_clock_source_bit;
   row_type     rows[6] = '{'{4'h0, 8'h00, 32'h04, 1'b0}, '{4'h0, 8'hFB, 32'hFF, 1'b0},
      '{4'h4, 8'h00, 32'hE0, 1'b0}, '{4'h4, 8'h1F, 32'hFF, 1'b0}, '{4'hC, 8'hFF, 32'h00, 1'b1},
      '{4'h8, 8'hFF, 32'h01, 1'b0}};

   // Basic variant, so the on-chip oscillator advice of the extended one never applies.
   power_down_clock_config #(.WAIT_8192(W0), .WAIT_16384(W1)) power_down_clock_config_inst (
      .mclk(mclk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .sleep_exec(sleep_exec), .wake_irq(wake_irq),
      .timer_clock_source_bit(timer_clock_source_bit),
      .watch_clk(watch_clk), .mode(mode), .cpu_hold(cpu_hold), .medium_clk(medium_clk),
      .sub_clk(sub_clk), .watch_clk_clean(watch_clk_clean));

   // ---------------------------------------------------------------
   // Clocks, compare and bus tasks
   // ---------------------------------------------------------------
   // Watch clock is 64 mclk cycles long so both noise sample rates divide it.
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      wcnt_reg <= wcnt_reg + 5'h01;
      if (wcnt_reg == 5'h1F) watch_clk <= ~watch_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // The request is held until pready is seen high, whatever the latency.
   task automatic apb(input logic wr, input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: {24'h0, d}};
      @(posedge mclk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata;
      er = apb_rsp.pslverr;
      apb_req <= '0;
   endtask

   task automatic pulse(input bit wake);
      @(posedge mclk);
      if (wake) wake_irq <= 1'b1;
      else sleep_exec <= 1'b1;
      @(posedge mclk);
      wake_irq <= 1'b0;
      sleep_exec <= 1'b0;
      #1;
   endtask

   // Counts mclk cycles between two rising edges of the chosen clock output.
   task automatic measure(input int which, output int per);
      int   r;
      int   k;
      logic prev;
      logic cur;
      r = 0;
      k = 0;
      prev = 1'b1;
      while (r < 2 && k < 4000) begin
         @(posedge mclk);
         #1;
         cur = (which == 0) ? medium_clk : (which == 1) ? sub_clk : watch_clk_clean;
         if (cur === 1'b1 && prev === 1'b0) begin
            r++;
            if (r == 1) k = 0;
         end
         prev = cur;
         k++;
      end
      per = k - 1;
   endtask

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      apb_req = '0;
      sleep_exec = 1'b0;
      wake_irq = 1'b0;
      timer_clock_source_bit = 1'b0;
      watch_clk = 1'b0;
      wcnt_reg = 5'h00;
      err_count = 0;
      n_compared = 0;
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      apb(1'b0, OFS_CONTROL_ONE, 8'h00);
      check(rd, 32'h07);
      apb(1'b0, OFS_CONTROL_TWO, 8'h00);
      check(rd, 32'hF0);
      $display("test reset done");
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].w);
         apb(1'b0, rows[i].a, 8'h00);
         check(rd, rows[i].r);
         check({31'h0, er}, {31'h0, rows[i].e});
      end
      apb(1'b1, OFS_CONTROL_TWO, 8'hF0);
      $display("test registers done");
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, OFS_CONTROL_ONE, 8'h04 | 8'(s));
         repeat (300) @(posedge mclk);
         measure(0, p);
         check(p, 16 << s);
      end
      $display("test medium divider done");
      // Sub select written now must not act until the sleep instruction.
      // At 40 MHz the oscillator is above 16 MHz, so the fast noise rate is allowed.
      apb(1'b1, OFS_CONTROL_TWO, 8'hF5);
      measure(1, p);
      check(p, 512);
      measure(2, p);
      check(p, 64);
      pulse(1'b0);
      check({23'h0, mode}, {23'h0, SLP_MED});
      check({31'h0, cpu_hold}, 32'h1);
      pulse(1'b1);
      check({23'h0, mode}, {23'h0, ACT_MED});
      repeat (700) @(posedge mclk);
      measure(1, p);
      check(p, 256);
      $display("test sleep and sub divider done");
      // The bench clock stands for an external clock, so the two-state code is legal.
      for (int k = 0; k < 8; k++) begin
         apb(1'b1, OFS_CONTROL_TWO, k[0] ? 8'hF4 : 8'hF0);
         apb(1'b1, OFS_CONTROL_ONE, 8'h87 | 8'(k << 4));
         pulse(1'b0);
         check({23'h0, mode}, {23'h0, STANDBY});
         pulse(1'b1);
         n = 0;
         while (mode === STAB_WAIT && n < 5000) begin
            @(posedge mclk);
            #1;
            n++;
         end
         check(n, exp_wait[k]);
         check({23'h0, mode}, k[0] ? {23'h0, ACT_MED} : {23'h0, ACT_HIGH});
      end
      $display("test stabilisation waits done");
      // Watch entry needs the timer source; waking with low speed on lands in subactive.
      apb(1'b1, OFS_CONTROL_ONE, 8'hDF);
      timer_clock_source_bit <= 1'b1;
      pulse(1'b0);
      check({23'h0, mode}, {23'h0, WATCH});
      pulse(1'b1);
      check({23'h0, mode}, {23'h0, SUB_ACT});
      apb(1'b1, OFS_CONTROL_TWO, 8'hFC);
      apb(1'b1, OFS_CONTROL_ONE, 8'hD7);
      pulse(1'b0);
      check({23'h0, mode}, {23'h0, STAB_WAIT});
      repeat (2) @(posedge mclk);
      #1;
      check({23'h0, mode}, {23'h0, ACT_MED});
      $display("test watch and direct transfer done");
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      check({23'h0, mode}, {23'h0, ACT_HIGH});
      rst_n <= 1'b1;
      apb(1'b0, OFS_CONTROL_ONE, 8'h00);
      check(rd, 32'h07);
      $display("test second reset done");
      final_report();
   end

   // A hang counts as a mismatch and ends the run the ordinary way.
   initial begin
      repeat (40000) @(posedge mclk);
      err_count++;
      final_report();
   end
endmodule
